//--- verilog/cpf_pkg.sv
// Constants, configuration layout and mode types of the logic fabric.
// Assumes one system clock; every pin reaches the fabric through synchronisers.
package cpf_pkg;
   localparam int NBLK     = 2;
   localparam int NMC      = 16;
   localparam int NROUTE   = 36;
   localparam int NPT_IN   = 2 * NROUTE;
   localparam int NPT      = 86;
   localparam int NGEN     = 80;
   localparam int PT_OE0   = 80;
   localparam int PT_SET   = 84;
   localparam int PT_RST   = 85;
   localparam int NDED     = 6;
   localparam int NCLK     = 4;
   localparam int CLK_SEL_W = 2;
   // Block 1 is the register-intensive variant
   localparam logic [NBLK-1:0] BLK_REG_INT = 2'h2;

   function automatic int io_count(input int b);
      return BLK_REG_INT[b] ? NMC / 2 : NMC;
   endfunction : io_count

   function automatic int io_base(input int b);
      int s;
      s = 0;
      for (int i = 0; i < b; i++) s += io_count(i);
      return s;
   endfunction : io_base

   localparam int NIO_TOT = io_base(NBLK);
   localparam int SRC_FB  = 0;
   localparam int SRC_DED = NBLK * NMC;
   localparam int SRC_IO  = SRC_DED + NDED;
   localparam int NSRC    = SRC_IO + NIO_TOT;
   localparam int SEL_W   = $clog2(NSRC + 1);

   localparam int MC_CFG_W   = 3;
   localparam int MC_INV_BIT = 2;
   localparam int IO_CFG_W   = 3;
   localparam int IO_SEL_BIT = 2;
   localparam int AR_SET_POL = 0;
   localparam int AR_RST_POL = 1;
   localparam int CLK_POL_BIT = CLK_SEL_W;

   localparam int OFS_ROUTE = 0;
   localparam int OFS_PT    = OFS_ROUTE + NROUTE * SEL_W;
   localparam int OFS_ALLOC = OFS_PT + NPT * NPT_IN;
   localparam int OFS_MC    = OFS_ALLOC + NMC * NGEN;
   localparam int OFS_IO    = OFS_MC + NMC * MC_CFG_W;
   localparam int OFS_AR    = OFS_IO + NMC * IO_CFG_W;
   localparam int OFS_CLK   = OFS_AR + 2;
   localparam int BLK_BITS  = OFS_CLK + CLK_SEL_W + 1;
   localparam int CFG_TOT   = NBLK * BLK_BITS;

   typedef enum logic [1:0] {MC_COMB, MC_DFF, MC_TFF, MC_LATCH} cpf_mc_mode_e;
   typedef enum logic [1:0] {OE_NEVER, OE_ALWAYS, OE_TERM, OE_SPARE} cpf_oe_mode_e;
endpackage : cpf_pkg

//--- verilog/cpf_macrocell.sv
// One macrocell register with its mode, output polarity and set/reset.
// Assumes clock enable and latch level already derived on the system clock.
`timescale 1ns/100ps
`default_nettype none
module cpf_macrocell
   import cpf_pkg::*;
(
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   input  wire logic         hold_i,
   input  wire logic         clk_en_i,
   input  wire logic         latch_open_i,
   input  wire logic         d_i,
   input  wire logic         set_i,
   input  wire logic         rst_i,
   input  wire cpf_mc_mode_e mode_i,
   input  wire logic         inv_i,
   output logic              q_o
);
   logic state_r;

   // Set and reset act every cycle, not only on the block clock edge
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_r <= 1'h0;
      end else if (hold_i || rst_i) begin
         state_r <= 1'h0;
      end else if (set_i) begin
         state_r <= 1'h1;
      end else begin
         case (mode_i)
            MC_DFF:   if (clk_en_i) state_r <= d_i;
            MC_TFF:   if (clk_en_i && d_i) state_r <= ~state_r;
            MC_LATCH: if (latch_open_i) state_r <= d_i;
            MC_COMB:  state_r <= d_i;
            default:  state_r <= 1'h0;
         endcase
      end
   end

   // Combinational mode bypasses the register for zero added latency
   // Held low during a load so a half-shifted pattern never reaches a pin
   assign q_o = hold_i ? 1'h0 : (((mode_i == MC_COMB) ? d_i : state_r) ^ inv_i);
endmodule : cpf_macrocell
`default_nettype wire

//--- verilog/cpf_fabric.sv
// Logic fabric: routing matrix, logic blocks and serial configuration store.
// Assumes pins and clock pins are asynchronous to clk_i; all are synchronised.
`timescale 1ns/100ps
`default_nettype none
module cpf_fabric
   import cpf_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               reset_i,
   input  wire logic [NIO_TOT-1:0] io_in_i,
   output logic      [NIO_TOT-1:0] io_out_o,
   output logic      [NIO_TOT-1:0] io_oe_o,
   input  wire logic [NDED-1:0]    ded_in_i,
   input  wire logic [NCLK-1:0]    clk_pin_i,
   input  wire logic               cfg_prog_en_i,
   input  wire logic               cfg_serial_clk_i,
   input  wire logic               config_serial_in_i,
   output logic                    config_serial_out_o,
   output logic                    cfg_loading_o
);
   logic [NIO_TOT-1:0] io_s1_r, io_s2_r;
   logic [NDED-1:0]    ded_s1_r, ded_s2_r;
   logic [NCLK-1:0]    ck_s1_r, ck_s2_r, ck_s3_r;
   logic [2:0]         ctl_s1_r, ctl_s2_r;
   logic               sclk_prev_r;
   logic               prog_s, sclk_s, sin_s, shift_en;
   logic [CFG_TOT-1:0] cfg_r;
   logic [NBLK*NMC-1:0] mc_q;
   logic [NSRC-1:0]    src_all;

   // Two-stage synchronisers; only the second stage is read
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         io_s1_r  <= '0;
         io_s2_r  <= '0;
         ded_s1_r <= '0;
         ded_s2_r <= '0;
      end else begin
         io_s1_r  <= io_in_i;
         io_s2_r  <= io_s1_r;
         ded_s1_r <= ded_in_i;
         ded_s2_r <= ded_s1_r;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ck_s1_r <= '0;
         ck_s2_r <= '0;
         ck_s3_r <= '0;
      end else begin
         ck_s1_r <= clk_pin_i;
         ck_s2_r <= ck_s1_r;
         ck_s3_r <= ck_s2_r;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ctl_s1_r    <= '0;
         ctl_s2_r    <= '0;
         sclk_prev_r <= 1'h0;
      end else begin
         ctl_s1_r    <= {cfg_prog_en_i, cfg_serial_clk_i, config_serial_in_i};
         ctl_s2_r    <= ctl_s1_r;
         sclk_prev_r <= ctl_s2_r[1];
      end
   end

   assign prog_s   = ctl_s2_r[2];
   assign sclk_s   = ctl_s2_r[1];
   assign sin_s    = ctl_s2_r[0];
   assign shift_en = prog_s && sclk_s && !sclk_prev_r;

   // Settings move only while a load is under way; otherwise frozen
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cfg_r <= '0;
      end else if (shift_en) begin
         cfg_r <= {cfg_r[CFG_TOT-2:0], sin_s};
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         config_serial_out_o <= 1'h0;
      end else if (shift_en) begin
         config_serial_out_o <= cfg_r[CFG_TOT-1];
      end
   end

   assign cfg_loading_o = prog_s;

   // Global source list: every feedback, dedicated input and I/O pin
   assign src_all = {io_s2_r, ded_s2_r, mc_q};

   for (genvar b = 0; b < NBLK; b++) begin : g_blk
      logic [BLK_BITS-1:0]  bc;
      logic [NROUTE-1:0]    sel_in;
      logic [NPT_IN-1:0]    field;
      logic [NPT-1:0]       pt;
      logic                 set_t, rst_t, lvl, lvl_prev, ck_en;
      logic [CLK_SEL_W-1:0] csel;
      logic                 cpol;

      assign bc = cfg_r[b*BLK_BITS +: BLK_BITS];

      // Each block draws its own picks from the full source list
      for (genvar r = 0; r < NROUTE; r++) begin : g_route
         logic [SEL_W-1:0] rsel;
         assign rsel = bc[OFS_ROUTE + r*SEL_W +: SEL_W];
         assign sel_in[r] = (rsel < NSRC) ? src_all[rsel] : 1'h0;
      end

      assign field = {~sel_in, sel_in};

      // Unused term (no input chosen) reads low so a blank part is idle
      for (genvar t = 0; t < NPT; t++) begin : g_pt
         logic [NPT_IN-1:0] m;
         assign m = bc[OFS_PT + t*NPT_IN +: NPT_IN];
         assign pt[t] = (|m) & (&(field | ~m));
      end

      assign set_t = pt[PT_SET] ^ bc[OFS_AR + AR_SET_POL];
      assign rst_t = pt[PT_RST] ^ bc[OFS_AR + AR_RST_POL];

      // Block clock from a synchronised pin; edge becomes an enable pulse
      assign csel     = bc[OFS_CLK +: CLK_SEL_W];
      assign cpol     = bc[OFS_CLK + CLK_POL_BIT];
      assign lvl      = ck_s2_r[csel] ^ cpol;
      assign lvl_prev = ck_s3_r[csel] ^ cpol;
      assign ck_en    = lvl && !lvl_prev;

      for (genvar m = 0; m < NMC; m++) begin : g_mc
         logic [NGEN-1:0]     amask;
         logic                sum;
         logic [MC_CFG_W-1:0] mcfg;
         // Own mask per macrocell: sharing a term never removes it elsewhere
         assign amask = bc[OFS_ALLOC + m*NGEN +: NGEN];
         assign sum   = |(pt[NGEN-1:0] & amask);
         assign mcfg  = bc[OFS_MC + m*MC_CFG_W +: MC_CFG_W];

         cpf_macrocell u_mc (
            .clk_i        (clk_i),
            .reset_i      (reset_i),
            .hold_i       (prog_s),
            .clk_en_i     (ck_en),
            .latch_open_i (lvl),
            .d_i          (sum),
            .set_i        (set_t),
            .rst_i        (rst_t),
            .mode_i       (cpf_mc_mode_e'(mcfg[1:0])),
            .inv_i        (mcfg[MC_INV_BIT]),
            .q_o          (mc_q[b*NMC + m])
         );
      end

      // Register-intensive blocks pin out even macrocells only
      for (genvar k = 0; k < io_count(b); k++) begin : g_io
         localparam int MCI  = BLK_REG_INT[b] ? 2 * k : k;
         localparam int OEB  = PT_OE0 + ((k < io_count(b) / 2) ? 0 : 2);
         logic [IO_CFG_W-1:0] icfg;
         logic                oe_t;
         cpf_oe_mode_e        om;
         assign icfg = bc[OFS_IO + k*IO_CFG_W +: IO_CFG_W];
         assign oe_t = pt[OEB + int'(icfg[IO_SEL_BIT])];
         assign om   = cpf_oe_mode_e'(icfg[1:0]);
         assign io_out_o[io_base(b) + k] = mc_q[b*NMC + MCI];
         always_comb begin
            case (om)
               OE_ALWAYS: io_oe_o[io_base(b) + k] = !prog_s;
               OE_TERM:   io_oe_o[io_base(b) + k] = !prog_s && oe_t;
               default:   io_oe_o[io_base(b) + k] = 1'h0;
            endcase
         end
      end
   end
endmodule : cpf_fabric
`default_nettype wire

//--- verif/cpf_fabric_checker.sv
// Port assertions for the logic fabric.
// Assumes serial clock phases of at least 3 clocks.
`timescale 1ns/100ps
`default_nettype none
module cpf_fabric_checker
   import cpf_pkg::*;
(
   input wire logic               clk_i,
   input wire logic               reset_i,
   input wire logic [NIO_TOT-1:0] io_out_o,
   input wire logic [NIO_TOT-1:0] io_oe_o,
   input wire logic               cfg_prog_en_i,
   input wire logic               config_serial_out_o,
   input wire logic               cfg_loading_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   a_load_oe_off: assert property (cfg_loading_o |-> io_oe_o == '0)
      else $error("oe on while loading");
   a_load_out_zero: assert property (cfg_loading_o && $past(cfg_loading_o) |-> io_out_o == '0)
      else $error("output not held during load");
   a_load_start: assert property ($rose(cfg_prog_en_i) |-> ##2 cfg_loading_o)
      else $error("load flag late");
   a_load_end: assert property ($fell(cfg_prog_en_i) |-> ##2 $fell(cfg_loading_o))
      else $error("load flag not cleared");
   a_rst_quiet: assert property ($fell(reset_i) |-> io_oe_o == '0 && io_out_o == '0)
      else $error("outputs active after reset");
   a_sout_idle: assert property (!cfg_loading_o && !$past(cfg_loading_o) |-> $stable(config_serial_out_o))
      else $error("serial out moved outside load");
   a_sout_gap: assert property ($changed(config_serial_out_o) |=> $stable(config_serial_out_o) [*4])
      else $error("serial out shifted twice too fast");
   a_sout_in_load: assert property ($changed(config_serial_out_o) |-> $past(cfg_loading_o))
      else $error("shift without load flag");
endmodule : cpf_fabric_checker
`default_nettype wire

//--- verif/cpf_board.sv
// Board logic on the fabric pins.
// Assumes no pull-ups; a released pin reads what the board drives.
`timescale 1ns/100ps
`default_nettype none
module cpf_board
   import cpf_pkg::*;
(
   input  wire logic [NIO_TOT-1:0] io_out_i,
   input  wire logic [NIO_TOT-1:0] io_oe_i,
   input  wire logic [NIO_TOT-1:0] drive_val_i,
   output logic      [NIO_TOT-1:0] pin_o
);
   // Board backs off where the device drives, so no contention
   assign pin_o = (io_oe_i & io_out_i) | (~io_oe_i & drive_val_i);
endmodule : cpf_board
`default_nettype wire

//--- verif/cpf_fabric_tb.sv
// Testbench for the logic fabric: serial load, then pin tests.
// Assumes the board model resolves shared pins.
`timescale 1ns/100ps
`default_nettype none
module cpf_fabric_tb;
   import cpf_pkg::*;
   logic               clk_i = 0;
   logic               reset_i = 1;
   logic [NIO_TOT-1:0] io_in, io_out, io_oe;
   logic [NIO_TOT-1:0] drv = '0;
   logic [NCLK-1:0]    cpin = '0;
   logic [NDED-1:0]    ded = '0;
   localparam int      CW = NIO_TOT + 2;
   logic               prog = 0, sclk = 0, config_serial_in = 0, config_serial_out, loading;
   logic [CFG_TOT-1:0] cfg = '0;
   int                 n_fail = 0, checked = 0;
   always #20 clk_i = ~clk_i;
   cpf_board u_board (.io_out_i(io_out), .io_oe_i(io_oe), .drive_val_i(drv), .pin_o(io_in));
   cpf_fabric u_dut (.clk_i(clk_i), .reset_i(reset_i), .io_in_i(io_in), .io_out_o(io_out),
      .io_oe_o(io_oe), .ded_in_i(ded), .clk_pin_i(cpin), .cfg_prog_en_i(prog),
      .cfg_serial_clk_i(sclk), .config_serial_in_i(config_serial_in), .config_serial_out_o(config_serial_out),
      .cfg_loading_o(loading));
   task automatic chk(input logic [CW-1:0] got, input logic [CW-1:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask : chk
   task automatic close_out;
      if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   // Data set with sclk low; both phases 3 clocks
   task automatic shift_bit(input logic b);
      config_serial_in = b;
      repeat (3) @(negedge clk_i);
      sclk = 1;
      repeat (3) @(negedge clk_i);
      sclk = 0;
   endtask : shift_bit
   task automatic wt(input int n);
      repeat (n) @(negedge clk_i);
   endtask : wt
   initial begin
      #3_960_000;
      n_fail++;
      $display("mismatch %0t watchdog", $time);
      close_out();
   end
   initial begin
      // Both blocks route pin 4; block 0 also routes pin 5
      cfg[OFS_ROUTE +: SEL_W] = SEL_W'(SRC_IO + 4);
      cfg[OFS_ROUTE + SEL_W +: SEL_W] = SEL_W'(SRC_IO + 5);
      cfg[BLK_BITS + OFS_ROUTE +: SEL_W] = SEL_W'(SRC_IO + 4);
      cfg[OFS_PT] = 1'b1;
      cfg[BLK_BITS + OFS_PT] = 1'b1;
      cfg[OFS_PT + PT_OE0 * NPT_IN + 1] = 1'b1;
      cfg[OFS_PT + (PT_OE0 + 2) * NPT_IN + NROUTE + 1] = 1'b1;
      // Term 0 shared by macrocells 0 and 1
      cfg[OFS_ALLOC] = 1'b1;
      cfg[OFS_ALLOC + NGEN] = 1'b1;
      cfg[BLK_BITS + OFS_ALLOC] = 1'b1;
      cfg[OFS_MC + MC_CFG_W +: MC_CFG_W] = 3'h1;
      cfg[OFS_IO +: IO_CFG_W] = 3'h1;
      cfg[OFS_IO + IO_CFG_W +: IO_CFG_W] = 3'h2;
      cfg[OFS_IO + 8 * IO_CFG_W +: IO_CFG_W] = 3'h2;
      cfg[OFS_IO + 9 * IO_CFG_W +: IO_CFG_W] = 3'h6;
      cfg[BLK_BITS + OFS_IO +: IO_CFG_W] = 3'h1;
      // Block 0: macrocell 2 shows buried block 1 macrocell 1, macrocell 3 latches
      cfg[OFS_ROUTE + 2 * SEL_W +: SEL_W] = SEL_W'(SRC_FB + NMC + 1);
      cfg[OFS_PT + NPT_IN + 2] = 1'b1;
      cfg[OFS_ALLOC + 2 * NGEN + 1] = 1'b1;
      cfg[OFS_ALLOC + 3 * NGEN] = 1'b1;
      cfg[OFS_MC + 3 * MC_CFG_W +: MC_CFG_W] = 3'h3;
      // Block 1: buried toggle on falling clock, set and reset from dedicated pins
      cfg[BLK_BITS + OFS_MC + MC_CFG_W +: MC_CFG_W] = 3'h2;
      cfg[BLK_BITS + OFS_ALLOC + NGEN] = 1'b1;
      cfg[BLK_BITS + OFS_ROUTE + SEL_W +: SEL_W] = SEL_W'(SRC_DED);
      cfg[BLK_BITS + OFS_ROUTE + 2 * SEL_W +: SEL_W] = SEL_W'(SRC_DED + 1);
      cfg[BLK_BITS + OFS_PT + PT_SET * NPT_IN + 1] = 1'b1;
      cfg[BLK_BITS + OFS_PT + PT_RST * NPT_IN + NROUTE + 2] = 1'b1;
      cfg[BLK_BITS + OFS_AR + AR_RST_POL] = 1'b1;
      cfg[CFG_TOT-1] = 1'b1;
      wt(8);
      reset_i = 0;
      wt(1);
      chk(CW'(io_oe), '0, "oe after reset");
      chk({io_out, config_serial_out, loading}, '0, "outputs after reset");
      prog = 1;
      wt(4);
      chk(CW'(io_oe), '0, "oe during load");
      for (int i = CFG_TOT - 1; i >= 0; i--) shift_bit(cfg[i]);
      prog = 0;
      wt(4);
      chk(CW'(io_out[0]), '0, "comb low");
      drv[4] = 1;
      wt(3);
      chk(CW'(io_out[0]), CW'(1'b1), "comb high");
      chk(CW'(io_out[16]), CW'(1'b1), "block1 comb");
      chk(CW'(io_oe[0]), CW'(1'b1), "oe always");
      chk(CW'(io_out[1]), '0, "dff before clock");
      chk(CW'(io_out[3:2]), '0, "latch and toggle idle");
      drv[5] = 1;
      wt(3);
      chk(CW'(io_oe[1]), CW'(1'b1), "upper oe term");
      chk(CW'({io_oe[9:8], io_oe[2]}), '0, "oe pairs");
      drv[5] = 0;
      wt(3);
      chk(CW'(io_oe[8]), CW'(1'b1), "lower oe term");
      chk(CW'(io_oe[1]), '0, "upper oe off");
      cpin[0] = 1;
      wt(6);
      chk(CW'(io_out[1]), CW'(1'b1), "dff clocked");
      chk(CW'(io_out[3:2]), CW'(2'h2), "latch open, no toggle on rise");
      cpin[0] = 0;
      wt(6);
      chk(CW'(io_out[3:1]), CW'(3'h7), "buried toggled on fall");
      drv[4] = 0;
      wt(3);
      chk(CW'({io_out[16], io_out[3], io_out[0]}), CW'(3'h2), "latch holds");
      ded[1] = 1;
      wt(4);
      chk(CW'(io_out[3:1]), CW'(3'h5), "reset term");
      ded[1] = 0;
      ded[0] = 1;
      wt(4);
      chk(CW'(io_out[3:1]), CW'(3'h7), "set term");
      ded[0] = 0;
      prog = 1;
      wt(4);
      chk(CW'({loading, io_oe}), CW'({1'b1, {NIO_TOT{1'b0}}}), "reload");
      shift_bit(1'b0);
      wt(2);
      chk(CW'(config_serial_out), CW'(1'b1), "serial out msb");
      close_out();
   end
endmodule : cpf_fabric_tb
bind cpf_fabric cpf_fabric_checker u_chk (.clk_i, .reset_i, .io_out_o, .io_oe_o, .cfg_prog_en_i,
   .config_serial_out_o, .cfg_loading_o);
`default_nettype wire
